// ===== design/stc_down_counter.sv
// Decrementing tick counter with wrap to a reload value.
// Assumes enable, clear and reload come from logic on the same clock.
`timescale 1ns/1ps
module stc_down_counter
  import stc_pkg::*;
#(
  parameter int CNT_W = STC_CNT_W          // Counter width
) (
  input  wire logic             aclk,       // Core clock
  input  wire logic             aresetn,    // Synchronous reset, active low
  input  wire logic             enable,     // Count while high
  input  wire logic             clear,      // One-cycle clear of the count
  input  wire logic [CNT_W-1:0] reload,     // Value loaded after zero
  output logic      [CNT_W-1:0] count,      // Present count
  output logic                  zero_pulse  // High in the cycle count became zero
);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);  // Decrement step

  logic [CNT_W-1:0] next_count;  // Count after this edge
  logic             next_zero;   // Zero event after this edge

  // Next count: clear beats counting, so a write always lands on zero
  always_comb begin
    next_count = count;
    next_zero  = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (enable) begin
      if (count == '0) begin
        next_count = reload;
      end else begin
        next_count = count - CNT_ONE;
        next_zero  = (count == CNT_ONE);
      end
    end
  end

  // Register the count; reset gives a defined zero so the first reload is clean
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count      <= '0;
      zero_pulse <= 1'b0;
    end else begin
      count      <= next_count;
      zero_pulse <= next_zero;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_clear_to_zero: assert property (clear |=> count == '0)
    else $error("count not zero after clear");
  chk_dec_step: assert property (enable && !clear && count != '0 |=>
                                 count == $past(count) - CNT_ONE)
    else $error("count did not step down by one");
  chk_wrap_reload: assert property (enable && !clear && count == '0 |=>
                                    count == $past(reload))
    else $error("count did not load reload value after zero");
  chk_zero_event: assert property (enable && !clear && count == CNT_ONE |=>
                                   zero_pulse && count == '0)
    else $error("zero event missing on transition to zero");
  chk_reload_hold: assert property (enable && !clear && count == '0 && reload == '0
                                    |=> count == '0 && !zero_pulse)
    else $error("zero reload did not hold counter at zero");
  chk_idle_stable: assert property (!enable && !clear |=> $stable(count) && !zero_pulse)
    else $error("count moved while disabled");
  cov_wrap: cover property (count == CNT_ONE ##1 count == '0 ##1 count == reload);
endmodule : stc_down_counter

// ===== design/stc_pkg.sv
// Constants, register map and helpers for the system tick timer.
// Assumes a 32-bit AXI4-Lite register bus and a single core clock.
package stc_pkg;
  // Counter geometry
  localparam int          STC_CNT_W      = 24;        // Width of the tick counter
  localparam int          STC_ADDR_W     = 8;         // Byte address bits decoded
  // Register byte offsets, one aligned word each
  localparam logic [7:0]  STC_OFS_CTRL   = 8'h00;     // Enable control
  localparam logic [7:0]  STC_OFS_RELOAD = 8'h04;     // Reload value
  localparam logic [7:0]  STC_OFS_CURR   = 8'h08;     // Current count, write clears
  localparam logic [7:0]  STC_OFS_STATUS = 8'h0C;     // Sticky events, read clears
  localparam logic [7:0]  STC_OFS_MASK   = 8'h10;     // Interrupt mask
  // Field positions
  localparam int          STC_CTRL_EN    = 0;         // Timer enable bit
  localparam int          STC_STAT_ZERO  = 0;         // Zero-reached flag bit
  // Reset values
  localparam logic        STC_EN_RST     = 1'h0;      // Timer stopped
  localparam logic        STC_MASK_RST   = 1'h0;      // Interrupt masked
  localparam logic        STC_FLAG_RST   = 1'h0;      // No event pending
  // Bus responses
  localparam logic [1:0]  STC_RESP_OKAY  = 2'h0;      // Access done
  localparam logic [1:0]  STC_RESP_SLVERR = 2'h2;     // Unmapped address

  // Merge a written word into an old value under byte strobes
  function automatic logic [31:0] stc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : stc_merge
endpackage : stc_pkg

// ===== design/stc_system_tick_timer.sv
// System tick timer: AXI4-Lite register slave around the tick counter.
// Assumes one master with at most one write and one read outstanding.
//
// Notes on behaviour
// - 24-bit down counter wrapping to reload value
// - Any write to current count clears it
// - Decrement each clock; reload the clock after zero
// - Transition to zero sets zero-reached flag
// - Reading status register clears zero-reached flag
// - Zero reload keeps counter parked at zero
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module stc_system_tick_timer
  import stc_pkg::*;
#(
  parameter int CNT_W  = STC_CNT_W,          // Counter width
  parameter int ADDR_W = STC_ADDR_W          // Decoded address width
) (
  input  wire logic              aclk,       // Core clock, 250 MHz
  input  wire logic              aresetn,    // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,     // Write address
  input  wire logic              awvalid,    // Write address valid
  output logic                   awready,    // Write address ready
  input  wire logic [31:0]       wdata,      // Write data
  input  wire logic [3:0]        wstrb,      // Write byte strobes
  input  wire logic              wvalid,     // Write data valid
  output logic                   wready,     // Write data ready
  output logic [1:0]             bresp,      // Write response
  output logic                   bvalid,     // Write response valid
  input  wire logic              bready,     // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,     // Read address
  input  wire logic              arvalid,    // Read address valid
  output logic                   arready,    // Read address ready
  output logic [31:0]            rdata,      // Read data
  output logic [1:0]             rresp,      // Read response
  output logic                   rvalid,     // Read data valid
  input  wire logic              rready,     // Read data ready
  output logic                   irq         // Level interrupt
);
  // Write channel state
  logic              aw_held,   next_aw_held;    // Address captured
  logic [ADDR_W-1:0] aw_addr,   next_aw_addr;    // Captured address
  logic              w_held,    next_w_held;     // Data captured
  logic [31:0]       w_data,    next_w_data;     // Captured data
  logic [3:0]        w_strb,    next_w_strb;     // Captured strobes
  logic              next_awready, next_wready;  // Ready for next beat
  logic              next_bvalid;                // Response pending
  logic [1:0]        next_bresp;                 // Response code
  // Read channel state
  logic              next_arready, next_rvalid;  // Read handshake state
  logic [31:0]       next_rdata;                 // Read word
  logic [1:0]        next_rresp;                 // Read code
  // Register file
  logic              ctrl_en,   next_ctrl_en;    // Timer enable
  logic [CNT_W-1:0]  reload,    next_reload;     // Reload value
  logic              mask_zero, next_mask_zero;  // Interrupt mask
  logic              zero_reached_flag, next_zero_reached_flag;  // Sticky event
  logic              clear_req, next_clear_req;  // Count clear strobe
  logic              next_irq;                   // Interrupt level
  // Counter link
  logic [CNT_W-1:0]  current_count;              // Live count
  logic              zero_pulse;                 // Count reached zero
  // Decode helpers
  logic              do_write;                   // Both write halves held
  logic              ar_take;                    // Read address handshake
  logic [31:0]       merged;                     // Written word under strobes
  logic              wr_mapped;                  // Write hits a register
  logic [7:0]        rd_ofs;                     // Read byte offset

  // Counter core runs every clock; the bus only steers it
  stc_down_counter #(
    .CNT_W      (CNT_W)
  ) u_counter (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .enable     (ctrl_en),
    .clear      (clear_req),
    .reload     (reload),
    .count      (current_count),
    .zero_pulse (zero_pulse)
  );

  // Word read back for an offset
  function automatic logic [31:0] read_word(input logic [7:0] ofs);
    logic [31:0] v;
    v = '0;
    unique case (ofs)
      STC_OFS_CTRL:   v[STC_CTRL_EN] = ctrl_en;
      STC_OFS_RELOAD: v[CNT_W-1:0] = reload;
      STC_OFS_CURR:   v[CNT_W-1:0] = current_count;
      STC_OFS_STATUS: v[STC_STAT_ZERO] = zero_reached_flag;
      STC_OFS_MASK:   v[STC_STAT_ZERO] = mask_zero;
      default:        v = '0;                         // Unmapped reads as zero
    endcase
    return v;
  endfunction : read_word

  // Whether an offset names a register
  function automatic logic is_mapped(input logic [7:0] ofs);
    return (ofs == STC_OFS_CTRL) || (ofs == STC_OFS_RELOAD) || (ofs == STC_OFS_CURR) ||
           (ofs == STC_OFS_STATUS) || (ofs == STC_OFS_MASK);
  endfunction : is_mapped

  // Write path: address and data are taken in either order, then one write
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl_en = ctrl_en;
    next_reload  = reload;
    next_mask_zero = mask_zero;
    next_clear_req = 1'b0;
    do_write     = aw_held && w_held && !bvalid;
    merged       = 32'h0;
    wr_mapped    = is_mapped(8'(aw_addr));
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_mapped ? STC_RESP_OKAY : STC_RESP_SLVERR;
      unique case (8'(aw_addr))
        STC_OFS_CTRL: begin
          merged       = stc_merge({31'h0, ctrl_en}, w_data, w_strb);
          next_ctrl_en = merged[STC_CTRL_EN];
        end
        STC_OFS_RELOAD: begin
          merged      = stc_merge(32'(reload), w_data, w_strb);
          next_reload = merged[CNT_W-1:0];
        end
        STC_OFS_CURR: begin
          next_clear_req = 1'b1;
        end
        STC_OFS_MASK: begin
          merged         = stc_merge({31'h0, mask_zero}, w_data, w_strb);
          next_mask_zero = merged[STC_STAT_ZERO];
        end
        default: begin
          merged = 32'h0;                             // Status and holes ignore writes
        end
      endcase
    end
    // Ready only while a slot is free, so a held beat never gets overwritten
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  // Read path and the sticky flag; a new event beats a read that clears it
  always_comb begin
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_zero_reached_flag = zero_reached_flag;
    ar_take      = arvalid && arready;
    rd_ofs       = 8'(araddr);
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rdata  = read_word(rd_ofs);
      next_rresp  = is_mapped(rd_ofs) ? STC_RESP_OKAY : STC_RESP_SLVERR;
      if (rd_ofs == STC_OFS_STATUS) begin
        next_zero_reached_flag = 1'b0;
      end
    end
    if (zero_pulse) begin
      next_zero_reached_flag = 1'b1;
    end
    next_arready = !next_rvalid;
    next_irq     = next_zero_reached_flag && next_mask_zero;
  end

  // Register every piece of bus and control state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      w_held    <= 1'b0;
      w_data    <= 32'h0;
      w_strb    <= 4'h0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= STC_RESP_OKAY;
      arready   <= 1'b0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0;
      rresp     <= STC_RESP_OKAY;
      ctrl_en   <= STC_EN_RST;
      reload    <= '0;
      mask_zero <= STC_MASK_RST;
      zero_reached_flag <= STC_FLAG_RST;
      clear_req <= 1'b0;
      irq       <= 1'b0;
    end else begin
      aw_held   <= next_aw_held;
      aw_addr   <= next_aw_addr;
      w_held    <= next_w_held;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      awready   <= next_awready;
      wready    <= next_wready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      arready   <= next_arready;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      ctrl_en   <= next_ctrl_en;
      reload    <= next_reload;
      mask_zero <= next_mask_zero;
      zero_reached_flag <= next_zero_reached_flag;
      clear_req <= next_clear_req;
      irq       <= next_irq;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_flag_on_zero: assert property (zero_pulse |=> zero_reached_flag)
    else $error("zero event did not set the flag");
  chk_flag_read_clear: assert property (ar_take && rd_ofs == STC_OFS_STATUS &&
                                        !zero_pulse |=> !zero_reached_flag && rvalid)
    else $error("status read did not clear the flag");
  chk_count_read: assert property (ar_take && rd_ofs == STC_OFS_CURR |=>
                                   rvalid && rdata[CNT_W-1:0] == $past(current_count))
    else $error("count read returned wrong value");
  chk_curr_write_clear: assert property (do_write && 8'(aw_addr) == STC_OFS_CURR
                                         |=> clear_req ##1 current_count == '0)
    else $error("count write did not clear counter");
  chk_irq_follows: assert property ($rose(zero_reached_flag) && mask_zero |-> irq)
    else $error("unmasked flag did not raise interrupt");
  chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  cov_irq: cover property (!irq ##1 irq);
  cov_status_read: cover property (ar_take && rd_ofs == STC_OFS_STATUS && zero_reached_flag);
  cov_clear_then_run: cover property (clear_req ##1 ctrl_en ##1 current_count == reload);
endmodule : stc_system_tick_timer

// ===== tb/testbench.sv
// Self-checking bench for the system tick timer register slave.
// Assumes the stc_pkg register map and a single 250 MHz core clock.
`timescale 1ns/1ps
module testbench
  import stc_pkg::*;
;
  logic        aclk    = 1'b0;      // Core clock
  logic        aresetn = 1'b0;      // Synchronous reset, active low
  logic [7:0]  awaddr  = 8'h00;     // Write address
  logic        awvalid = 1'b0;      // Write address valid
  logic        awready;             // Write address ready
  logic [31:0] wdata   = 32'h0;     // Write data
  logic [3:0]  wstrb   = 4'h0;      // Write strobes
  logic        wvalid  = 1'b0;      // Write data valid
  logic        wready;              // Write data ready
  logic [1:0]  bresp;               // Write response
  logic        bvalid;              // Write response valid
  logic        bready  = 1'b0;      // Write response ready
  logic [7:0]  araddr  = 8'h00;     // Read address
  logic        arvalid = 1'b0;      // Read address valid
  logic        arready;             // Read address ready
  logic [31:0] rdata;               // Read data
  logic [1:0]  rresp;               // Read response
  logic        rvalid;              // Read data valid
  logic        rready  = 1'b0;      // Read data ready
  logic        irq;                 // Level interrupt
  int          n_mismatch = 0;      // Mismatches seen
  int          checked    = 0;      // Comparisons made
  int          cyc        = 0;      // Free-running cycle count
  logic [3:0]  strb       = 4'hF;   // Byte strobes used by the next write

  // Clock: 4 ns period
  always #2 aclk = ~aclk;

  // Cycle stamp, used to predict count differences between reads
  always @(posedge aclk) cyc <= cyc + 1;

  stc_system_tick_timer dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq(irq)
  );

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Verdict and end of run, shared with the watchdog
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // One write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int  n;
    bit  done;
    n = 0;
    done = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= strb; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        done = 1;
        check("bresp", {30'h0, bresp}, {30'h0, er});
      end
    end
    if (!done) check("write answer", 32'h0, 32'h1);
  endtask : wr

  // One read: returns data and the cycle stamp of the address handshake
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d,
                    output int c);
    int  n;
    bit  done;
    n = 0;
    done = 0;
    c = 0;
    d = 32'h0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge aclk);
      n++;
      if (arvalid === 1'b1 && arready === 1'b1) begin
        arvalid <= 1'b0;
        c = cyc;
      end
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        done = 1;
        d = rdata;
        check("rresp", {30'h0, rresp}, {30'h0, er});
      end
    end
    if (!done) check("read answer", 32'h0, 32'h1);
  endtask : rd

  // Let registered outputs land before sampling them
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask : settle

  // Reset values, unmapped and ignored accesses, reload width
  task automatic t_regs;
    logic [31:0] d;
    int          c;
    rd(STC_OFS_CTRL, STC_RESP_OKAY, d, c);  check("ctrl reset", d, 32'h0);
    rd(STC_OFS_MASK, STC_RESP_OKAY, d, c);  check("mask reset", d, 32'h0);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c); check("status reset", d, 32'h0);
    check("irq reset", {31'h0, irq}, 32'h0);
    wr(8'h14, 32'hFFFFFFFF, STC_RESP_SLVERR);
    rd(8'h40, STC_RESP_SLVERR, d, c);       check("unmapped data", d, 32'h0);
    wr(STC_OFS_STATUS, 32'hFFFFFFFF, STC_RESP_OKAY);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c); check("status ignores write", d, 32'h0);
    wr(STC_OFS_RELOAD, 32'hFFFFFFFF, STC_RESP_OKAY);
    rd(STC_OFS_RELOAD, STC_RESP_OKAY, d, c); check("reload width", d, 32'h00FFFFFF);
    // Only the low byte lane is strobed, so the upper reload bytes must survive
    strb = 4'h1;
    wr(STC_OFS_RELOAD, 32'h00000012, STC_RESP_OKAY);
    strb = 4'hF;
    rd(STC_OFS_RELOAD, STC_RESP_OKAY, d, c); check("reload strobe", d, 32'h00FFFF12);
    wr(STC_OFS_CURR, 32'h00ABCDEF, STC_RESP_OKAY);
    settle();
    rd(STC_OFS_CURR, STC_RESP_OKAY, d, c);  check("clear on write", d, 32'h0);
    $display("test regs done");
  endtask : t_regs

  // Pairs of count reads must differ by elapsed cycles, modulo reload+1
  task automatic t_count(input int r);
    logic [31:0] v1, v2;
    int          c1, c2, e;
    wr(STC_OFS_CTRL, 32'h0, STC_RESP_OKAY);
    wr(STC_OFS_RELOAD, r, STC_RESP_OKAY);
    wr(STC_OFS_CURR, 32'h5A5A5A5A, STC_RESP_OKAY);
    wr(STC_OFS_CTRL, 32'h1 << STC_CTRL_EN, STC_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      rd(STC_OFS_CURR, STC_RESP_OKAY, v1, c1);
      rd(STC_OFS_CURR, STC_RESP_OKAY, v2, c2);
      e = (int'(v1) - (c2 - c1)) % (r + 1);
      if (e < 0) e += r + 1;
      check("count in range", {31'h0, v1 <= r}, 32'h1);
      check("count step", v2, e);
    end
    $display("test count reload %0d done", r);
  endtask : t_count

  // Flag sets on reaching zero, raises irq when unmasked, read clears it
  task automatic t_flag;
    logic [31:0] d;
    int          c;
    wr(STC_OFS_CTRL, 32'h0, STC_RESP_OKAY);
    wr(STC_OFS_RELOAD, 32'd40, STC_RESP_OKAY);
    wr(STC_OFS_CURR, 32'h0, STC_RESP_OKAY);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c);
    wr(STC_OFS_CTRL, 32'h1, STC_RESP_OKAY);
    repeat (100) @(posedge aclk);
    wr(STC_OFS_CTRL, 32'h0, STC_RESP_OKAY);
    settle();
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(STC_OFS_MASK, 32'h1, STC_RESP_OKAY);
    settle();
    check("irq unmasked", {31'h0, irq}, 32'h1);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c); check("flag set", d, 32'h1);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c); check("flag cleared", d, 32'h0);
    $display("test flag done");
  endtask : t_flag

  // Zero reload parks the count with the enable still set
  task automatic t_park;
    logic [31:0] d;
    int          c;
    wr(STC_OFS_RELOAD, 32'h0, STC_RESP_OKAY);
    wr(STC_OFS_CURR, 32'h0, STC_RESP_OKAY);
    wr(STC_OFS_CTRL, 32'h1, STC_RESP_OKAY);
    repeat (50) @(posedge aclk);
    rd(STC_OFS_CURR, STC_RESP_OKAY, d, c);  check("parked count", d, 32'h0);
    rd(STC_OFS_CTRL, STC_RESP_OKAY, d, c);  check("enable kept", d, 32'h1);
    rd(STC_OFS_STATUS, STC_RESP_OKAY, d, c); check("no flag parked", d, 32'h0);
    check("irq parked", {31'h0, irq}, 32'h0);
    $display("test park done");
  endtask : t_park

  // Main sequence: reset for three cycles, then each scenario
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_count(1000);
    t_count(5);
    t_flag();
    t_park();
    end_of_test();
  end

  // Watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("FAIL watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule : testbench
